/* hdl/frame_filter.v */
// receive frame filter: header parser, row table, verdict, AXI4-Lite regs
// assumes a byte stream on clk with sof/eof framing from the rx datapath
`timescale 1ns/100ps
`include "frame_filter_defs.vh"

module frame_filter #(
  parameter ROWS = 8,
  parameter ROWS_400 = 4,
  parameter KW = `FLT_KW
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // received frame bytes
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_sof,
  input wire rx_eof,
  // per-frame verdict
  output reg frame_pass_r,
  output reg frame_drop_r,
  // axi4-lite write
  input wire [`ADDR_W-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [`ADDR_W-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready
);

  localparam [3:0] S_MAC = 4'h0;
  localparam [3:0] S_TYPE = 4'h1;
  localparam [3:0] S_VLAN = 4'h2;
  localparam [3:0] S_BTAG = 4'h3;
  localparam [3:0] S_ITAG = 4'h4;
  localparam [3:0] S_PBB = 4'h5;
  localparam [3:0] S_MPLS = 4'h6;
  localparam [3:0] S_TPMAC = 4'h7;
  localparam [3:0] S_IPV4 = 4'h8;
  localparam [3:0] S_IPV6 = 4'h9;
  localparam [3:0] S_L4 = 4'hA;
  localparam [3:0] S_LLC = 4'hB;
  localparam [3:0] S_DONE = 4'hC;
  localparam [ROWS-1:0] LIM400 = {ROWS{1'b1}} >> (ROWS - ROWS_400);

  // configuration
  reg filt_en_r;
  reg rate400_r;
  reg [2:0] encap_sel_r;
  reg [ROWS-1:0] row_en_r;
  reg [15:0] pat_off_r;
  reg [31:0] sel_r [0:ROWS-1];
  reg [31:0] mke_r [0:ROWS-1];
  reg [31:0] val_mem [0:ROWS*KW-1];
  reg [31:0] msk_mem [0:ROWS*KW-1];
  // status
  reg last_pass_r;
  reg [2:0] last_enc_r;
  reg [ROWS-1:0] last_hits_r;
  reg [31:0] pass_cnt_r;
  reg [31:0] drop_cnt_r;
  // parser, then axi write address, data and strobe holding
  reg [3:0] st_r;
  reg [7:0] rel_r;
  reg [15:0] cnt_r;
  reg [7:0] hi_r;
  reg [3:0] vcnt_r;
  reg [3:0] mcnt_r;
  reg [3:0] ihl_r;
  reg [7:0] proto_r;
  reg bos_r;
  reg typed_r;
  reg [2:0] encap_r;
  reg eval_r;
  reg [7:0] key_r [0:KW*4-1];
  reg [`ADDR_W-1:0] aw_addr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  integer ix;
  integer jx;

  // parser next state
  reg [3:0] st, st_nxt, vc, vc_nxt, mc, mc_nxt, ihl_nxt;
  reg [7:0] rel, rel_nxt, hi_nxt, proto_nxt, kidx, v4end;
  reg [15:0] cnt, typ;
  reg [2:0] enc, enc_nxt;
  reg typed, typed_nxt, bos_nxt, kwe;

  always @*
  begin
    st = rx_sof ? S_MAC : st_r;
    rel = rx_sof ? 8'h00 : rel_r;
    cnt = rx_sof ? 16'h0000 : cnt_r;
    vc = rx_sof ? 4'h0 : vcnt_r;
    mc = rx_sof ? 4'h0 : mcnt_r;
    enc = rx_sof ? 3'h0 : encap_r;
    typed = rx_sof ? 1'b0 : typed_r;
    st_nxt = st;
    rel_nxt = rel + 8'h01;
    hi_nxt = hi_r;
    ihl_nxt = ihl_r;
    proto_nxt = proto_r;
    bos_nxt = bos_r;
    vc_nxt = vc;
    mc_nxt = mc;
    enc_nxt = enc;
    typed_nxt = typed;
    kwe = 1'b0;
    kidx = 8'h00;
    typ = {hi_r, rx_data};
    v4end = (ihl_r < 4'h5) ? 8'h13 : {2'b00, ihl_r, 2'b00} - 8'h01;
    case (st)
      S_MAC:
      begin
        kwe = 1'b1;
        kidx = (rel < 8'h06) ? rel : rel + 8'h02;
        if (rel == 8'h0B)
        begin
          st_nxt = S_TYPE;
          rel_nxt = 8'h00;
        end
      end
      S_TYPE:
      begin
        if (rel == 8'h00)
          hi_nxt = rx_data;
        else
        begin
          rel_nxt = 8'h00;
          if (!typed && typ != `ET_CTAG && typ != `ET_BTAG)
          begin
            typed_nxt = 1'b1;
            if (typ >= `ET_MIN)
              enc_nxt[`ENC_ETH] = 1'b1;
          end
          case (typ)
            `ET_CTAG: st_nxt = S_VLAN;
            `ET_BTAG: st_nxt = S_BTAG;
            `ET_ITAG: st_nxt = S_ITAG;
            `ET_MPLS, `ET_MPLSM: st_nxt = S_MPLS;
            `ET_IPV4: st_nxt = S_IPV4;
            `ET_IPV6: st_nxt = S_IPV6;
            default: st_nxt = (typ < `ET_MIN && !typed) ? S_LLC : S_DONE;
          endcase
        end
      end
      S_VLAN:
      begin
        // one key word per vlan level
        kwe = (vc < `MAX_LEVELS);
        kidx = `K_VLAN + {2'b00, vc, 2'b00} + rel;
        if (rel == 8'h01)
        begin
          vc_nxt = (vc < `MAX_LEVELS) ? vc + 4'h1 : vc;
          st_nxt = S_TYPE;
          rel_nxt = 8'h00;
        end
      end
      S_BTAG, S_ITAG:
      begin
        kwe = 1'b1;
        kidx = ((st == S_BTAG) ? `K_BTAG : `K_ITAG) + rel;
        if ((st == S_BTAG && rel == 8'h01) || rel == 8'h03)
        begin
          st_nxt = (st == S_BTAG) ? S_TYPE : S_PBB;
          rel_nxt = 8'h00;
        end
      end
      S_PBB, S_TPMAC:
      begin
        kwe = 1'b1;
        kidx = ((st == S_PBB) ? `K_PBD : `K_TPD) + ((rel < 8'h06) ? rel : rel + 8'h02);
        if (rel == 8'h0B)
        begin
          st_nxt = S_TYPE;
          rel_nxt = 8'h00;
        end
      end
      S_MPLS:
      begin
        // one key word per label level
        kwe = (mc < `MAX_LEVELS);
        kidx = `K_MPLS + {2'b00, mc, 2'b00} + rel;
        if (rel == 8'h02)
          bos_nxt = rx_data[0];
        if (rel == 8'h03)
        begin
          mc_nxt = (mc < `MAX_LEVELS) ? mc + 4'h1 : mc;
          st_nxt = bos_r ? S_TPMAC : S_MPLS;
          rel_nxt = 8'h00;
        end
      end
      S_IPV4:
      begin
        if (rel == 8'h00)
          ihl_nxt = rx_data[3:0];
        if (rel == 8'h09)
          proto_nxt = rx_data;
        kwe = (rel >= 8'h0C && rel <= 8'h13);
        kidx = `K_V4 + rel - 8'h0C;
        if (rel >= 8'h13 && rel == v4end)
        begin
          st_nxt = (proto_r == `PR_TCP || proto_r == `PR_UDP) ? S_L4 : S_DONE;
          rel_nxt = 8'h00;
        end
      end
      S_IPV6:
      begin
        if (rel == 8'h06)
          proto_nxt = rx_data;
        kwe = (rel >= 8'h08 && rel <= 8'h27);
        kidx = `K_V6 + rel - 8'h08;
        if (rel == 8'h27)
        begin
          st_nxt = (proto_r == `PR_TCP || proto_r == `PR_UDP) ? S_L4 : S_DONE;
          rel_nxt = 8'h00;
        end
      end
      S_L4:
      begin
        kwe = 1'b1;
        kidx = (rel < 8'h02) ? `K_SP + rel : `K_DP + rel - 8'h02;
        if (rel == 8'h03)
          st_nxt = S_DONE;
      end
      S_LLC:
      begin
        hi_nxt = rx_data;
        if (rel == 8'h01)
        begin
          if (hi_r == `SNAP_SAP && rx_data == `SNAP_SAP)
            enc_nxt[`ENC_SNAP] = 1'b1;
          else
            enc_nxt[`ENC_LLC] = 1'b1;
          st_nxt = S_DONE;
        end
      end
      default:
      begin
        st_nxt = S_DONE;
        rel_nxt = rel;
      end
    endcase
  end

  // offset counted from first dst MAC byte
  wire [15:0] pdiff = cnt - pat_off_r;
  // four pattern bytes at the offset
  wire pwe = (cnt >= pat_off_r) && (pdiff < 16'h0004);
  wire [7:0] pidx = `K_PAT + {6'h00, pdiff[1:0]};

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= S_DONE;
      rel_r <= 8'h00;
      cnt_r <= 16'h0000;
      hi_r <= 8'h00;
      vcnt_r <= 4'h0;
      mcnt_r <= 4'h0;
      ihl_r <= 4'h0;
      proto_r <= 8'h00;
      bos_r <= 1'b0;
      typed_r <= 1'b0;
      encap_r <= 3'h0;
      eval_r <= 1'b0;
      for (ix = 0; ix < KW*4; ix = ix + 1)
        key_r[ix] <= 8'h00;
    end
    else
    begin
      eval_r <= rx_valid && rx_eof;
      if (rx_valid)
      begin
        st_r <= st_nxt;
        rel_r <= rel_nxt;
        cnt_r <= (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
        hi_r <= hi_nxt;
        vcnt_r <= vc_nxt;
        mcnt_r <= mc_nxt;
        ihl_r <= ihl_nxt;
        proto_r <= proto_nxt;
        bos_r <= bos_nxt;
        typed_r <= typed_nxt;
        encap_r <= enc_nxt;
        if (rx_sof)
          for (ix = 0; ix < KW*4; ix = ix + 1)
            key_r[ix] <= 8'h00;
        if (kwe)
          key_r[kidx] <= rx_data;
        if (pwe)
          key_r[pidx] <= rx_data;
      end
    end
  end

  // flatten key and row tables for the row matchers
  wire [KW*32-1:0] key_flat;
  wire [ROWS*KW*32-1:0] val_flat;
  wire [ROWS*KW*32-1:0] msk_flat;
  wire [ROWS-1:0] hits;
  wire [ROWS-1:0] row_on = row_en_r & (rate400_r ? LIM400 : {ROWS{1'b1}});

  genvar b, r;
  generate
    for (b = 0; b < KW*4; b = b + 1)
    begin : g_key
      assign key_flat[(b/4)*32 + (3 - b%4)*8 +: 8] = key_r[b];
    end
    for (r = 0; r < ROWS*KW; r = r + 1)
    begin : g_tab
      assign val_flat[r*32 +: 32] = val_mem[r];
      assign msk_flat[r*32 +: 32] = msk_mem[r];
    end
    for (r = 0; r < ROWS; r = r + 1)
    begin : g_row
      row_match #(.KW(KW)) u_row (
        .key(key_flat),
        .val(val_flat[r*KW*32 +: KW*32]),
        .msk(msk_flat[r*KW*32 +: KW*32]),
        .sel(sel_r[r]),
        .mke(mke_r[r]),
        .on(row_on[r]),
        .hit(hits[r])
      );
    end
  endgenerate

  wire gate = (encap_sel_r == 3'h0) || ((encap_sel_r & encap_r) != 3'h0);
  // row result combined with the gate
  wire verdict = !filt_en_r || (gate && (hits != {ROWS{1'b0}}));

  wire wr_go = !awready && !wready && !bvalid;
  wire clr_pass = wr_go && aw_addr_r[13:12] == `RG_CTRL && aw_addr_r[11:0] == `A_PASSN;
  wire clr_drop = wr_go && aw_addr_r[13:12] == `RG_CTRL && aw_addr_r[11:0] == `A_DROPN;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      frame_pass_r <= 1'b0;
      frame_drop_r <= 1'b0;
      last_pass_r <= 1'b0;
      last_enc_r <= 3'h0;
      last_hits_r <= {ROWS{1'b0}};
      pass_cnt_r <= 32'h0000_0000;
      drop_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      frame_pass_r <= eval_r && verdict;
      frame_drop_r <= eval_r && !verdict;
      pass_cnt_r <= (clr_pass ? 32'h0000_0000 : pass_cnt_r) + {31'h0, eval_r && verdict};
      drop_cnt_r <= (clr_drop ? 32'h0000_0000 : drop_cnt_r) + {31'h0, eval_r && !verdict};
      if (eval_r)
      begin
        last_pass_r <= verdict;
        last_enc_r <= encap_r;
        last_hits_r <= hits;
      end
    end
  end

  // table index of a row-word address
  function [8:0] midx_f;
    input [`ADDR_W-1:0] a;
    integer t;
    begin
      t = a[10:8] * KW + a[7:2];
      midx_f = t[8:0];
    end
  endfunction

  // register read: {mapped, data}
  function [32:0] rd_f;
    input [`ADDR_W-1:0] a;
    reg ok;
    reg [31:0] d;
    begin
      ok = 1'b0;
      d = 32'h0000_0000;
      if (a[13:12] == `RG_VAL || a[13:12] == `RG_MSK)
      begin
        if (a[10:8] < ROWS && a[7:2] < KW)
        begin
          ok = 1'b1;
          d = a[12] ? val_mem[midx_f(a)] : msk_mem[midx_f(a)];
        end
      end
      else if (a[13:12] == `RG_CTRL)
      begin
        ok = 1'b1;
        case ({a[11:2], 2'b00})
          `A_CTRL: d = {21'h0, encap_sel_r, 6'h0, rate400_r, filt_en_r};
          `A_ROWEN: d[ROWS-1:0] = row_en_r;
          `A_PATOFF: d = {16'h0000, pat_off_r};
          `A_STATUS:
          begin
            d[8 +: ROWS] = last_hits_r;
            d[3:0] = {last_enc_r, last_pass_r};
          end
          `A_PASSN: d = pass_cnt_r;
          `A_DROPN: d = drop_cnt_r;
          default:
          begin
            ok = (a[11:6] == `A_ROWCFG) && (a[5:3] < ROWS);
            if (ok)
              d = a[2] ? mke_r[a[5:3]] : sel_r[a[5:3]];
          end
        endcase
      end
      rd_f = {ok, d};
    end
  endfunction

  always @(posedge clk)
  begin : axi_w
    reg [32:0] old;
    reg [31:0] bm, m;
    if (!reset_n)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_r <= {`ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      filt_en_r <= 1'b0;
      rate400_r <= 1'b0;
      encap_sel_r <= `ENCSEL_RST;
      row_en_r <= `ROWEN_RST;
      pat_off_r <= `PATOFF_RST;
      for (jx = 0; jx < ROWS; jx = jx + 1)
      begin
        sel_r[jx] <= 32'h0000_0000;
        mke_r[jx] <= 32'h0000_0000;
      end
      for (jx = 0; jx < ROWS*KW; jx = jx + 1)
      begin
        val_mem[jx] <= 32'h0000_0000;
        msk_mem[jx] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (awready && awvalid)
      begin
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wready && wvalid)
      begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go)
      begin
        old = rd_f(aw_addr_r);
        bm = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        m = (old[31:0] & ~bm) | (wdata_r & bm);
        bvalid <= 1'b1;
        bresp <= old[32] ? `RESP_OKAY : `RESP_SLVERR;
        if (old[32])
        begin
          if (aw_addr_r[13:12] == `RG_VAL)
            val_mem[midx_f(aw_addr_r)] <= m;
          else if (aw_addr_r[13:12] == `RG_MSK)
            msk_mem[midx_f(aw_addr_r)] <= m;
          else
            case ({aw_addr_r[11:2], 2'b00})
              `A_CTRL:
              begin
                filt_en_r <= m[`CTRL_EN];
                rate400_r <= m[`CTRL_R400];
                encap_sel_r <= m[`CTRL_ENC +: 3];
              end
              `A_ROWEN: row_en_r <= m[ROWS-1:0];
              `A_PATOFF: pat_off_r <= m[15:0];
              `A_STATUS, `A_PASSN, `A_DROPN: ;
              default:
                if (aw_addr_r[2])
                  mke_r[aw_addr_r[5:3]] <= m;
                else
                  sel_r[aw_addr_r[5:3]] <= m;
            endcase
        end
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin : axi_r
    reg [32:0] q;
    if (!reset_n)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      q = rd_f(araddr);
      rdata <= q[31:0];
      rresp <= q[32] ? `RESP_OKAY : `RESP_SLVERR;
      rvalid <= 1'b1;
      arready <= 1'b0;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // frame_filter

/* hdl/row_match.v */
// one filter row: masked compare of the selected key words
// assumes key and row words share the same word layout
`timescale 1ns/100ps
`include "frame_filter_defs.vh"

module row_match #(
  parameter KW = `FLT_KW
) (
  // captured header words
  input wire [KW*32-1:0] key,
  // row values, masks, field selects
  input wire [KW*32-1:0] val,
  input wire [KW*32-1:0] msk,
  input wire [31:0] sel,
  input wire [31:0] mke,
  input wire on,
  // result
  output wire hit
);

  // key word to field number
  function integer fid;
    input integer w;
    begin
      if (w < 12)
        fid = w / 2;
      else if (w < 16)
        fid = w - 6;
      else if (w < 20)
        fid = 10;
      else if (w < 24)
        fid = 11;
      else
        fid = w - 12;
    end
  endfunction

  wire [KW-1:0] ok;

  genvar w;
  generate
    for (w = 0; w < KW; w = w + 1)
    begin : g_w
      localparam integer F = fid(w);
      wire [31:0] care = mke[F] ? msk[w*32 +: 32] : 32'hFFFF_FFFF;
      assign ok[w] = !sel[F] || (((key[w*32 +: 32] ^ val[w*32 +: 32]) & care) == 32'h0000_0000);
    end
  endgenerate

  assign hit = on && (&ok);

endmodule // row_match

/* pkg/frame_filter_defs.vh */
// constants for the receive frame filter: map, key layout, codes
// assumes inclusion by bare name from the design files
//
// Summary of operation
// - eight filter rows, each enabled row evaluated
// - fields ANDed in row, rows ORed
// - mask one compares bit, zero ignores it
// - at 400G only four rows usable
// - per-row 32-bit pattern at programmed offset
// - offset counts bytes from destination MAC start
// - one pattern offset shared by all rows
// - selectable masked compares on listed header fields
// - eight MPLS and VLAN levels, independently set
// - encapsulation gate: ethertype, SNAP, LLC selections
// - empty encapsulation selection opens the gate for every frame
`ifndef FRAME_FILTER_DEFS_VH
`define FRAME_FILTER_DEFS_VH

// key words per row and capture depth per tag stack
`define FLT_KW 43
`define MAX_LEVELS 4'h8

// key byte bases, fields left-aligned in 32-bit words
`define K_DMAC 8'h00
`define K_TPD 8'h10
`define K_PBD 8'h20
`define K_BTAG 8'h30
`define K_ITAG 8'h34
`define K_V4 8'h38
`define K_V6 8'h40
`define K_SP 8'h60
`define K_DP 8'h64
`define K_PAT 8'h68
`define K_VLAN 8'h6C
`define K_MPLS 8'h8C

// header codes
`define ET_CTAG 16'h8100
`define ET_BTAG 16'h88A8
`define ET_ITAG 16'h88E7
`define ET_MPLS 16'h8847
`define ET_MPLSM 16'h8848
`define ET_IPV4 16'h0800
`define ET_IPV6 16'h86DD
`define ET_MIN 16'h0600
`define SNAP_SAP 8'hAA
`define PR_TCP 8'h06
`define PR_UDP 8'h11

// encapsulation class bits
`define ENC_ETH 0
`define ENC_SNAP 1
`define ENC_LLC 2

// register map, byte addresses, region in addr[13:12]
`define ADDR_W 14
`define A_CTRL 12'h000
`define A_ROWEN 12'h004
`define A_PATOFF 12'h008
`define A_STATUS 12'h00C
`define A_PASSN 12'h010
`define A_DROPN 12'h014
`define A_ROWCFG 6'h01
`define RG_CTRL 2'b00
`define RG_VAL 2'b01
`define RG_MSK 2'b10

// control fields and reset values
`define CTRL_EN 0
`define CTRL_R400 1
`define CTRL_ENC 8
`define ROWEN_RST 8'h00
`define PATOFF_RST 16'h0000
`define ENCSEL_RST 3'h0

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* test/frame_filter_checker.sv */
// port assertions for the receive frame filter
// assumes a bind onto frame_filter from the testbench top
`timescale 1ns/100ps
`include "frame_filter_defs.vh"
module frame_filter_checker (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // frame stream and verdict
  input wire rx_valid,
  input wire rx_eof,
  input wire frame_pass_r,
  input wire frame_drop_r,
  // axi4-lite handshakes
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence eof_taken;
    rx_valid && rx_eof;
  endsequence
  sequence verdict;
    frame_pass_r || frame_drop_r;
  endsequence
  verdict_excl_a: assert property (!(frame_pass_r && frame_drop_r))
    else $error("pass and drop high together");
  verdict_time_a: assert property (eof_taken |-> ##[2:3] verdict)
    else $error("no verdict after frame end");
  verdict_cause_a: assert property (verdict |-> $past(rx_valid && rx_eof, 2)
    || $past(rx_valid && rx_eof, 3))
    else $error("verdict without frame end");
  aw_hold_a: assert property ((awvalid && awready) || (!awready && !(bvalid && bready))
    |=> !awready)
    else $error("write address accepted twice");
  b_time_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response latency wrong");
  b_release_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channel not released");
  r_time_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response latency wrong");
  r_release_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not released");
  r_error_a: assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h00000000)
    else $error("error read returned data");
endmodule // frame_filter_checker

/* test/link_sender.sv */
// remote sender: plays a stored frame as a byte stream, optionally with gaps
// assumes the bench loads mem and calls start away from the clock edge
`timescale 1ns/100ps
module link_sender (
  // clock
  input wire clk,
  // byte stream toward the filter
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rx_sof,
  output reg rx_eof
);
  reg [7:0] mem [0:63];
  reg slow = 1'b0;
  reg gap_r = 1'b0;
  integer len = 0;
  integer idx = 0;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
  end
  always @(posedge clk)
  begin
    gap_r <= ~gap_r;
    if (idx < len && !(slow && gap_r))
    begin
      rx_valid <= 1'b1;
      rx_data <= mem[idx];
      rx_sof <= (idx == 0);
      rx_eof <= (idx == len - 1);
      idx <= idx + 1;
    end
    else
    begin
      // idle byte keeps changing so a stale value never looks valid
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
  task start(input integer n);
  begin
    idx = 0;
    len = n;
  end
  endtask
endmodule // link_sender

/* test/testbench.sv */
// self-checking bench for the receive frame filter
// assumes link_sender as the remote sender and the checker bound below
`timescale 1ns/100ps
`include "frame_filter_defs.vh"
`define CHK(got, exp) \
  begin \
    n_checks = n_checks + 1; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [`ADDR_W-1:0] awaddr = 14'h0000;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h00000000;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [`ADDR_W-1:0] araddr = 14'h0000;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire rx_valid, rx_sof, rx_eof, frame_pass_r, frame_drop_r;
  wire awready, wready, bvalid, arready, rvalid;
  wire [7:0] rx_data;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_mismatch = 0;
  integer n_checks = 0;
  localparam [47:0] DST = 48'h00123456789A;
  link_sender link_sender_i (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_eof(rx_eof));
  frame_filter frame_filter_i (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .frame_pass_r(frame_pass_r),
    .frame_drop_r(frame_drop_r), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial forever #4 clk = ~clk;
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  // waits for the answer however long it takes; only the watchdog ends a hang
  task axw(input [13:0] a, input [31:0] d);
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    while (!bvalid)
    begin
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      @(posedge clk);
    end
    bready <= 1'b0;
    `CHK(bresp, `RESP_OKAY)
  end
  endtask
  task axr(input [13:0] a, input [31:0] d, input [1:0] r);
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (!rvalid)
    begin
      if (arready)
        arvalid <= 1'b0;
      @(posedge clk);
    end
    rready <= 1'b0;
    `CHK(({rresp, rdata}), ({r, d}))
  end
  endtask
  // builds a 64-byte frame: dst, fixed src 0A..0F, type, two bytes, then index bytes
  task frame(input [47:0] dst, input [15:0] typ, input [15:0] llc, input exp);
    integer i;
  begin
    for (i = 0; i < 64; i = i + 1)
      link_sender_i.mem[i] = (i < 6) ? dst[47 - 8 * i -: 8] : (i < 12) ? 8'h04 + i[7:0] : i[7:0];
    link_sender_i.mem[12] = typ[15:8];
    link_sender_i.mem[13] = typ[7:0];
    link_sender_i.mem[14] = llc[15:8];
    link_sender_i.mem[15] = llc[7:0];
    @(negedge clk);
    link_sender_i.start(64);
    for (i = 0; i < 300 && !(frame_pass_r || frame_drop_r); i = i + 1)
      @(negedge clk);
    `CHK(({frame_pass_r, frame_drop_r}), (exp ? 2'b10 : 2'b01))
  end
  endtask
  task t_reset;
  begin
    axr(14'h0000, 32'h00000000, `RESP_OKAY);
    axr(14'h0004, 32'h00000000, `RESP_OKAY);
    axr(14'h0008, 32'h00000000, `RESP_OKAY);
    axr(14'h3000, 32'h00000000, `RESP_SLVERR);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
  end
  endtask
  task t_rows;
  begin
    axw(14'h0000, 32'h00000001);
    frame(DST, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0040, 32'h00000001);
    axw(14'h1000, 32'h00123456);
    axw(14'h1004, 32'h789A0000);
    axw(14'h0004, 32'h00000001);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    frame(DST ^ 48'h1, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0040, 32'h00000003);
    frame(DST, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0004, 32'h00000041);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    link_sender_i.slow = 1'b1;
    axw(14'h0004, 32'h00000040);
    frame(48'h0, 16'h0800, 16'h0000, 1'b1);
    link_sender_i.slow = 1'b0;
  end
  endtask
  task t_mask;
  begin
    axw(14'h0040, 32'h00000001);
    axw(14'h0044, 32'h00000001);
    axw(14'h2000, 32'h00FF00FF);
    axw(14'h2004, 32'hFFFF0000);
    axw(14'h0004, 32'h00000001);
    frame(48'h55125556789A, 16'h0800, 16'h0000, 1'b1);
    frame(48'h00135556789A, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0044, 32'h00000000);
    axw(14'h0040, 32'h00000000);
  end
  endtask
  task t_pattern;
  begin
    axw(14'h0008, 32'h00000007);
    axw(14'h0050, 32'h00004000);
    axw(14'h1268, 32'h0B0C0D0E);
    axw(14'h0048, 32'h00004000);
    axw(14'h1168, 32'h0C0D0E0F);
    axw(14'h0004, 32'h00000004);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    axw(14'h0008, 32'h00000008);
    frame(DST, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0004, 32'h00000006);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    axw(14'h0050, 32'h00000000);
    axw(14'h0048, 32'h00000000);
  end
  endtask
  task t_rate;
  begin
    axw(14'h0004, 32'h00000020);
    axw(14'h0000, 32'h00000003);
    frame(DST, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0004, 32'h00000008);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    axw(14'h0000, 32'h00000001);
    axw(14'h0004, 32'h00000020);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
  end
  endtask
  task t_gate;
  begin
    axw(14'h0000, 32'h00000101);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    frame(DST, 16'h002E, 16'hAAAA, 1'b0);
    axw(14'h0000, 32'h00000201);
    frame(DST, 16'h002E, 16'hAAAA, 1'b1);
    frame(DST, 16'h002E, 16'h4242, 1'b0);
    axw(14'h0000, 32'h00000401);
    frame(DST, 16'h002E, 16'h4242, 1'b1);
    axw(14'h0000, 32'h00000001);
    frame(DST, 16'h002E, 16'h4242, 1'b1);
  end
  endtask
  // ipv4 dst is frame bytes 30..33, vlan level 1 tci is bytes 14..15
  task t_fields;
  begin
    axw(14'h0040, 32'h00000200);
    axw(14'h103C, 32'h1E1F2021);
    axw(14'h0004, 32'h00000001);
    frame(DST, 16'h0800, 16'h0000, 1'b1);
    axw(14'h103C, 32'h1E1F2022);
    frame(DST, 16'h0800, 16'h0000, 1'b0);
    axw(14'h0040, 32'h00008000);
    axw(14'h106C, 32'h12340000);
    frame(DST, 16'h8100, 16'h1234, 1'b1);
    frame(DST, 16'h8100, 16'h1235, 1'b0);
    axr(14'h000C, 32'h00000002, `RESP_OKAY);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_rows;
    t_mask;
    t_pattern;
    t_rate;
    t_gate;
    t_fields;
    complete_run;
  end
endmodule // testbench
bind frame_filter frame_filter_checker frame_filter_checker_i (.clk(clk), .reset_n(reset_n),
  .rx_valid(rx_valid), .rx_eof(rx_eof), .frame_pass_r(frame_pass_r),
  .frame_drop_r(frame_drop_r), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
